// ---- hdl/clock_loss_detector.sv ----
// Missing-clock one-shot on a sampled clock level
`timescale 1ns/10ps
module clock_loss_detector
  import reset_source_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = MCD_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Control and monitored level
  input  wire logic enable_i,
  input  wire logic mon_clk_i,
  // Timeout pulse
  output logic      timeout_o
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYCLES);

  initial begin
    if (TIMEOUT_CYCLES < 1) $error("TIMEOUT_CYCLES must be at least 1");
  end

  logic          last_r;
  logic [CW-1:0] same_r;

  always_ff @(posedge clk_i) begin
    last_r <= srst_i ? 1'b0 : mon_clk_i;
  end

  // Any edge retriggers the one-shot
  always_ff @(posedge clk_i) begin
    if (srst_i || !enable_i || (mon_clk_i != last_r) || timeout_o) begin
      same_r    <= '0;
      timeout_o <= 1'b0;
    end else begin
      same_r    <= same_r + CW'(1);
      timeout_o <= (same_r == LIMIT - CW'(1));
    end
  end

endmodule // clock_loss_detector

// ---- hdl/reset_source_logic.sv ----
// Reset source collection, sequencing and cause register
//
// Functional notes
// RULE1: Writing one to bit 5 enables comparator as reset source.
// RULE2: Enabled comparator low output forces system reset.
// RULE3: Bit 5 reads one only after comparator reset.
// RULE4: Software enables comparator and waits to settle before enabling reset.
// RULE5: Internal resets never touch the external reset pin.
// RULE6: Watchdog comes up enabled after any reset, clocked core clock/12.
// RULE7: Watchdog overflow resets and sets bit 3.
// RULE8: Flash write-enabled data write at reserved address resets.
// RULE9: Code read at reserved address resets.
// RULE10: Fetch or branch into reserved region resets.
// RULE11: Security-forbidden flash access resets.
// RULE12: Flash access without high-threshold enabled supply monitor resets.
// RULE13: Bit 6 reads one after flash error reset; read-only.
// RULE14: Writing one to bit 4 forces reset; reads one afterwards.
// RULE15: Bit 2 enables clock-loss detector; reads one after its reset.
// RULE16: Bit 1 enables supply monitor reset; reads one after power-on.
// RULE17: Software enables supply monitor only once it is stable.
// RULE18: Bit 0 read-only, one after external pin reset.
// RULE19: Software avoids read-modify-write on the cause register.
// RULE20: Stuck clock level resets; writing zero disables detector.
// RULE21: Low pin holds reset; pin flag set on leaving it. The code sets the cause flags on entry to the reset instead.
// RULE22: Level select zero low, one high; high needed for flash.
// RULE23: Each reset leaves only the newest cause flag set.
// RULE24: Bit 7 reads zero, ignores writes.
`timescale 1ns/10ps
module reset_source_logic
  import reset_source_pkg::*;
#(
  parameter logic [15:0] RESERVED_BASE  = RESERVED_BASE_DEF,
  parameter int          WD_WIDTH       = 8,
  parameter int          HOLD_CYCLES    = RESET_HOLD_CYC,
  parameter int          MCD_CYCLES     = MCD_TIMEOUT_CYC
) (
  // Clock and power-on clear
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Register access from the core
  input  wire sfr_req_t   sfr_i,
  output logic [7:0]      sfr_rdata_o,
  // Reset sources
  input  wire logic       pin_rst_n_i,
  input  wire logic       cmp_out_i,
  input  wire logic       supply_trip_i,
  input  wire logic       supply_monitor_level_i,
  input  wire logic       core_clock_i,
  input  wire flash_acc_t flash_i,
  // Watchdog control from the counter array
  input  wire logic       wd_kick_i,
  input  wire logic       wd_disable_i,
  // Status and system reset
  output logic            sys_reset_o,
  output logic            wd_enabled_o,
  output logic            cmp_reset_en_o,
  output logic            mcd_en_o,
  output logic            supply_reset_en_o
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES - 1);

  initial begin
    if (HOLD_CYCLES < 1) $error("HOLD_CYCLES must be at least 1");
    if (MCD_CYCLES < 1) $error("MCD_CYCLES must be at least 1");
    if (WD_WIDTH < 2) $error("WD_WIDTH must be at least 2");
    // A zero base would turn every flash access into an error reset
    if (RESERVED_BASE == 16'h0000) $error("RESERVED_BASE leaves no user flash");
  end

  // Highest-priority request wins; the result is one-hot
  function automatic logic [7:0] pick_cause(input logic [7:0] req);
    logic [7:0] one;
    one = FLAGS_NONE;
    if (req[BIT_POR]) begin
      one[BIT_POR] = 1'b1;
    end else if (req[BIT_PIN]) begin
      one[BIT_PIN] = 1'b1;
    end else if (req[BIT_MCD]) begin
      one[BIT_MCD] = 1'b1;
    end else if (req[BIT_FERR]) begin
      one[BIT_FERR] = 1'b1;
    end else if (req[BIT_WDT]) begin
      one[BIT_WDT] = 1'b1;
    end else if (req[BIT_CMP]) begin
      one[BIT_CMP] = 1'b1;
    end else if (req[BIT_SW]) begin
      one[BIT_SW] = 1'b1;
    end
    return one;
  endfunction

  seq_state_t    state_r;
  seq_state_t    state_nxt;
  logic [HW-1:0] hold_r;
  logic [HW-1:0] hold_nxt;
  logic [7:0]    flags_r;
  logic [7:0]    req;
  logic          cmp_en_r;
  logic          mcd_en_r;
  logic          vdm_en_r;
  logic          reg_sel;
  logic          reg_wr;
  logic          wd_overflow;
  logic          mcd_timeout;
  logic          in_reserved;
  logic          store_wr;
  logic          flash_op;
  logic          flash_err;
  logic          sub_srst;

  assign reg_sel = (sfr_i.addr == CAUSE_REG_ADDR);
  // Writes during reset are dropped; the core is not running then
  assign reg_wr  = reg_sel && sfr_i.wr && (state_r == SEQ_RUN);
  // Submodules restart on power-on and on every system reset
  assign sub_srst = srst_i || sys_reset_o;

  watchdog_timer #(
    .WD_WIDTH (WD_WIDTH)
  ) u_wdt (
    .clk_i      (clk_i),
    .srst_i     (sub_srst),        // [RULE6]
    .kick_i     (wd_kick_i),
    .disable_i  (wd_disable_i),
    .enabled_o  (wd_enabled_o),
    .overflow_o (wd_overflow)
  );

  clock_loss_detector #(
    .TIMEOUT_CYCLES (MCD_CYCLES)
  ) u_mcd (
    .clk_i     (clk_i),
    .srst_i    (sub_srst),
    .enable_i  (mcd_en_r),         // [RULE20]
    .mon_clk_i (core_clock_i),
    .timeout_o (mcd_timeout)
  );

  // Flash error decode
  assign in_reserved = (flash_i.addr >= RESERVED_BASE);
  assign store_wr    = flash_i.xdata_wr && flash_i.store_wr_en;
  assign flash_op    = store_wr || flash_i.code_rd || flash_i.erase;

  always_comb begin
    flash_err = 1'b0;
    // Erase is a write too, so it is refused above user space as well
    if ((store_wr || flash_i.erase) && in_reserved) begin
      flash_err = 1'b1;                                    // [RULE8]
    end
    if (flash_i.code_rd && in_reserved) begin
      flash_err = 1'b1;                                    // [RULE9]
    end
    if (flash_i.fetch && in_reserved) begin
      flash_err = 1'b1;                                    // [RULE10]
    end
    if (flash_op && flash_i.sec_deny) begin
      flash_err = 1'b1;                                    // [RULE11]
    end
    // High threshold is level select one
    if (flash_op && !(supply_monitor_level_i && vdm_en_r)) begin
      flash_err = 1'b1;                                    // [RULE12] [RULE22]
    end
  end

  // Gather requests into cause-bit positions
  always_comb begin
    req              = FLAGS_NONE;
    req[BIT_PIN]     = !pin_rst_n_i;                       // [RULE21]
    req[BIT_POR]     = vdm_en_r && supply_trip_i;          // [RULE16]
    req[BIT_MCD]     = mcd_timeout;                        // [RULE15] [RULE20]
    req[BIT_WDT]     = wd_overflow;                        // [RULE7]
    req[BIT_SW]      = reg_wr && sfr_i.wdata[BIT_SW];      // [RULE14]
    req[BIT_CMP]     = cmp_en_r && !cmp_out_i;             // [RULE2]
    req[BIT_FERR]    = flash_err;
  end

  // Sequencer: hold the system reset for a least time, longer while pin low
  always_comb begin
    state_nxt = state_r;
    hold_nxt  = hold_r;
    case (state_r)
      SEQ_RUN: begin
        if (|req) begin
          state_nxt = SEQ_HOLD;
          hold_nxt  = HOLD_LOAD;
        end
      end
      SEQ_HOLD: begin
        if (!pin_rst_n_i) begin
          hold_nxt = HOLD_LOAD;                            // [RULE21]
        end else if (hold_r == '0) begin
          state_nxt = SEQ_RUN;
        end else begin
          hold_nxt = hold_r - HW'(1);
        end
      end
      default: begin
        state_nxt = SEQ_RUN;
        hold_nxt  = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= SEQ_HOLD;
      hold_r  <= HOLD_LOAD;
    end else begin
      state_r <= state_nxt;
      hold_r  <= hold_nxt;
    end
  end

  // Only an internal system reset is driven; the pin has no driver here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= (state_nxt == SEQ_HOLD);              // [RULE5]
    end
  end

  // Cause flags: replaced as a whole on entry to each reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_r <= FLAGS_POR;                                // [RULE16]
    end else if ((state_r == SEQ_RUN) && (|req)) begin
      flags_r <= pick_cause(req);                          // [RULE23] [RULE3] [RULE13] [RULE18]
    end
  end

  // Comparator enable; cleared so a held-low output cannot loop resets
  always_ff @(posedge clk_i) begin
    if (srst_i || sys_reset_o) begin
      cmp_en_r <= 1'b0;
    end else if (reg_wr) begin
      cmp_en_r <= sfr_i.wdata[BIT_CMP];                    // [RULE1]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || sys_reset_o) begin
      mcd_en_r <= 1'b0;
    end else if (reg_wr) begin
      mcd_en_r <= sfr_i.wdata[BIT_MCD];                    // [RULE15] [RULE20]
    end
  end

  // Supply monitor stays a reset source across non-power-on resets
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      vdm_en_r <= 1'b1;
    end else if (reg_wr) begin
      vdm_en_r <= sfr_i.wdata[BIT_POR];                    // [RULE16]
    end
  end

  // Read port; the unused top bit always reads zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sfr_rdata_o <= FLAGS_NONE;
    end else if (reg_sel && sfr_i.rd) begin
      sfr_rdata_o <= {1'b0, flags_r[BIT_UNUSED-1:0]};      // [RULE24]
    end else begin
      sfr_rdata_o <= FLAGS_NONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmp_reset_en_o    <= 1'b0;
      mcd_en_o          <= 1'b0;
      supply_reset_en_o <= 1'b1;
    end else begin
      cmp_reset_en_o    <= cmp_en_r;
      mcd_en_o          <= mcd_en_r;
      supply_reset_en_o <= vdm_en_r;
    end
  end

endmodule // reset_source_logic

// ---- hdl/reset_source_pkg.sv ----
// Shared constants and carrier types for the reset source logic
package reset_source_pkg;

  // Core clock period
  localparam int CLK_PERIOD_NS = 10;

  // Reset cause register address and width
  localparam logic [7:0] CAUSE_REG_ADDR  = 8'hef;
  localparam int         CAUSE_REG_WIDTH = 8;

  // Field positions inside the reset cause register
  localparam int BIT_PIN    = 0;
  localparam int BIT_POR    = 1;
  localparam int BIT_MCD    = 2;
  localparam int BIT_WDT    = 3;
  localparam int BIT_SW     = 4;
  localparam int BIT_CMP    = 5;
  localparam int BIT_FERR   = 6;
  localparam int BIT_UNUSED = 7;

  // Flag value after power-on: only the power-on flag set
  localparam logic [7:0] FLAGS_POR = 8'h02;
  localparam logic [7:0] FLAGS_NONE = 8'h00;

  // Watchdog prescaler: core clock divided by twelve
  localparam int WD_PRESCALE = 12;

  // Missing-clock timeout, longest time, rounded down
  localparam int MCD_TIMEOUT_NS  = 1000;
  localparam int MCD_TIMEOUT_RAW = MCD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int MCD_TIMEOUT_CYC = (MCD_TIMEOUT_RAW < 1) ? 1 : MCD_TIMEOUT_RAW;

  // Least time a system reset is held, rounded up
  localparam int RESET_HOLD_NS  = 200;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default start of the reserved flash region
  localparam logic [15:0] RESERVED_BASE_DEF = 16'hf000;

  // Sequencer states
  typedef enum logic {
    SEQ_RUN,
    SEQ_HOLD
  } seq_state_t;

  // Special-function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // One flash-related access from the core
  typedef struct packed {
    logic [15:0] addr;
    logic        xdata_wr;
    logic        code_rd;
    logic        fetch;
    logic        erase;
    logic        store_wr_en;
    logic        sec_deny;
  } flash_acc_t;

endpackage : reset_source_pkg

// ---- hdl/watchdog_timer.sv ----
// Counter-array watchdog, prescaled from the core clock
`timescale 1ns/10ps
module watchdog_timer
  import reset_source_pkg::*;
#(
  parameter int WD_WIDTH = 8
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Software control
  input  wire logic kick_i,
  input  wire logic disable_i,
  // Status
  output logic      enabled_o,
  output logic      overflow_o
);

  localparam int PW = $clog2(WD_PRESCALE);
  localparam logic [PW-1:0] PRE_LAST = PW'(WD_PRESCALE - 1);

  initial begin
    if (WD_WIDTH < 2) $error("WD_WIDTH must be at least 2");
  end

  logic [PW-1:0]       pre_r;
  logic [WD_WIDTH-1:0] cnt_r;
  logic                tick;

  assign tick = (pre_r == PRE_LAST);

  always_ff @(posedge clk_i) begin
    if (srst_i || tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  // Any reset brings the watchdog back up armed
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      enabled_o <= 1'b1;
    end else if (disable_i) begin
      enabled_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || kick_i || !enabled_o) begin
      cnt_r      <= '0;
      overflow_o <= 1'b0;
    end else if (tick) begin
      cnt_r      <= cnt_r + WD_WIDTH'(1);
      overflow_o <= &cnt_r;
    end else begin
      overflow_o <= 1'b0;
    end
  end

endmodule // watchdog_timer

// ---- tb/reset_source_logic_chk.sv ----
// Port-level assertions for the reset source logic
`timescale 1ns/10ps
module reset_source_logic_chk
  import reset_source_pkg::*;
#(
  parameter logic [15:0] RESERVED_BASE = RESERVED_BASE_DEF,
  parameter int          HOLD_CYCLES   = RESET_HOLD_CYC,
  parameter int          MCD_CYCLES    = MCD_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Observed inputs
  input  wire sfr_req_t   sfr_i,
  input  wire logic       pin_rst_n_i,
  input  wire logic       cmp_out_i,
  input  wire logic       supply_monitor_level_i,
  input  wire logic       core_clock_i,
  input  wire flash_acc_t flash_i,
  // Observed outputs
  input  wire logic [7:0] sfr_rdata_o,
  input  wire logic       sys_reset_o,
  input  wire logic       wd_enabled_o,
  input  wire logic       cmp_reset_en_o,
  input  wire logic       mcd_en_o,
  input  wire logic       supply_reset_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic        reg_wr;
  logic        fl_use;
  logic        bad_addr;
  logic [15:0] hi_cnt;
  logic [15:0] run_cnt;
  logic [15:0] stuck_cnt;
  assign reg_wr   = sfr_i.wr && (sfr_i.addr == CAUSE_REG_ADDR);
  assign fl_use   = (flash_i.xdata_wr && flash_i.store_wr_en) || flash_i.code_rd || flash_i.erase;
  assign bad_addr = (flash_i.addr >= RESERVED_BASE) && (fl_use || flash_i.fetch);
  // Pulse length in total, and since the pin last asked for hold
  always_ff @(posedge clk_i) begin
    hi_cnt <= srst_i ? 16'h0001 : (sys_reset_o ? hi_cnt + 16'h0001 : 16'h0000);
  end
  always_ff @(posedge clk_i) begin
    run_cnt <= (srst_i || !pin_rst_n_i || !sys_reset_o) ? 16'h0000 : run_cnt + 16'h0001;
  end
  // Cycles the watched level has sat still with the detector on
  always_ff @(posedge clk_i) begin
    if (srst_i || !(mcd_en_o && $stable(core_clock_i))) begin
      stuck_cnt <= 16'h0000;
    end else begin
      stuck_cnt <= stuck_cnt + 16'h0001;
    end
  end
  a_sw_force: assert property (
    reg_wr && sfr_i.wdata[BIT_SW] && !sys_reset_o |=> sys_reset_o)
    else $error("software force did not reset");
  // Enable output lags a write by one cycle, so skip just after writes
  a_cmp_trigger: assert property (
    cmp_reset_en_o && !cmp_out_i && !sys_reset_o && !$past(reg_wr) |=> sys_reset_o)
    else $error("comparator low did not reset");
  a_flash_supply: assert property (
    fl_use && !(supply_monitor_level_i && supply_reset_en_o) && !sys_reset_o
    && !$past(reg_wr) |=> sys_reset_o)
    else $error("flash access at low supply did not reset");
  a_flash_illegal: assert property (
    (bad_addr || (flash_i.sec_deny && fl_use)) && !sys_reset_o |=> sys_reset_o)
    else $error("illegal flash access did not reset");
  a_pin_hold: assert property (!pin_rst_n_i |=> sys_reset_o)
    else $error("low pin did not hold reset");
  a_hold_min: assert property ($fell(sys_reset_o) |-> hi_cnt >= HOLD_CYCLES)
    else $error("reset pulse too short");
  a_hold_max: assert property (sys_reset_o |-> run_cnt <= HOLD_CYCLES + 2)
    else $error("reset pulse not released");
  a_read_flags: assert property (
    sfr_i.rd |=> !sfr_rdata_o[BIT_UNUSED] && $countones(sfr_rdata_o) <= 1)
    else $error("cause flags not one-hot");
  a_wd_rearm: assert property ($fell(sys_reset_o) |-> wd_enabled_o)
    else $error("watchdog not enabled after reset");
  a_mcd_stuck: assert property (
    stuck_cnt == MCD_CYCLES |-> ##[0:3] sys_reset_o)
    else $error("stuck clock did not reset");
  c_any_reset: cover property ($rose(sys_reset_o));
  c_pin_reset: cover property (!pin_rst_n_i ##1 sys_reset_o);
  c_sw_reset: cover property (reg_wr && sfr_i.wdata[BIT_SW]);
endmodule // reset_source_logic_chk

bind reset_source_logic reset_source_logic_chk #(
  .RESERVED_BASE(RESERVED_BASE),
  .HOLD_CYCLES  (HOLD_CYCLES),
  .MCD_CYCLES   (MCD_CYCLES)
) chk (
  .clk_i, .srst_i, .sfr_i, .pin_rst_n_i, .cmp_out_i, .supply_monitor_level_i,
  .core_clock_i, .flash_i, .sfr_rdata_o, .sys_reset_o, .wd_enabled_o,
  .cmp_reset_en_o, .mcd_en_o, .supply_reset_en_o
);

// ---- tb/test_reset_source_logic.sv ----
// Self-checking bench for the reset source logic
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module test_reset_source_logic;
  import reset_source_pkg::*;
  localparam int HOLD   = 4;
  localparam int WD_W   = 8;
  localparam int WD_CYC = WD_PRESCALE * (2 ** WD_W);
  localparam logic [15:0] RB = RESERVED_BASE_DEF;
  localparam flash_acc_t FL_CASE [7] = '{
    '{RB, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'hffff, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
    '{RB, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0},
    '{16'h0100, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1},
    '{RB - 16'h0001, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'h0100, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
    '{16'h0100, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}};
  localparam logic [6:0] FL_BAD = 7'h2f;
  localparam logic [6:0] FL_LOW = 7'h20;
  logic       clk_i = 1'b0;
  logic       srst_i = 1'b1;
  sfr_req_t   sfr_i = '0;
  logic       pin_rst_n_i = 1'b1;
  logic       cmp_out_i = 1'b1;
  logic       supply_trip_i = 1'b0;
  logic       supply_monitor_level_i = 1'b1;
  logic       core_clock_i = 1'b0;
  flash_acc_t flash_i = '0;
  logic       wd_kick_i = 1'b0;
  logic       wd_disable_i = 1'b0;
  logic       clk_run = 1'b1;
  logic [7:0] sfr_rdata_o;
  logic [7:0] rd_v;
  logic       sys_reset_o, wd_enabled_o, cmp_reset_en_o, mcd_en_o, supply_reset_en_o, seen;
  int         n_mismatch = 0;
  int         cmp_count = 0;

  always #5 clk_i = ~clk_i;
  // Monitored clock level; stopping it models a missing clock
  always @(posedge clk_i) if (clk_run) #1 core_clock_i = ~core_clock_i;

  reset_source_logic #(.HOLD_CYCLES(HOLD), .WD_WIDTH(WD_W), .MCD_CYCLES(4)) DUT (
    .clk_i, .srst_i, .sfr_i, .sfr_rdata_o, .pin_rst_n_i, .cmp_out_i, .supply_trip_i,
    .supply_monitor_level_i, .core_clock_i, .flash_i, .wd_kick_i, .wd_disable_i,
    .sys_reset_o, .wd_enabled_o, .cmp_reset_en_o, .mcd_en_o, .supply_reset_en_o);

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Accesses end with an idle cycle so two calls never collide in one step
  task automatic reg_wr(input logic [7:0] d);
    sfr_i = '{addr: CAUSE_REG_ADDR, wr: 1'b1, rd: 1'b0, wdata: d};
    step(1);
    sfr_i = '0;
    step(1);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    sfr_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    step(1);
    sfr_i = '0;
    d = sfr_rdata_o;
    step(1);
  endtask
  task automatic quiet(input int n);
    seen = 1'b0;
    repeat (n) begin
      step(1);
      seen = seen | sys_reset_o;
    end
    `CHK("no reset", 1'b0, seen)
  endtask
  task automatic cause(input logic [7:0] e);
    int k = 0;
    while (sys_reset_o !== 1'b1 && k < WD_CYC + 100) begin
      step(1);
      k++;
    end
    `CHK("reset entered", 1'b1, sys_reset_o)
    while (sys_reset_o !== 1'b0 && k < WD_CYC + 200) begin
      step(1);
      k++;
    end
    reg_rd(CAUSE_REG_ADDR, rd_v);
    `CHK("cause flags", e, rd_v)
  endtask
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    step(10);
    srst_i = 1'b0;
    step(HOLD + 2);
    reg_rd(CAUSE_REG_ADDR, rd_v);
    `CHK("power-on flags", FLAGS_POR, rd_v)
    `CHK("supply enable", 1'b1, supply_reset_en_o)
    `CHK("watchdog on", 1'b1, wd_enabled_o)
    reg_rd(8'h80, rd_v);
    `CHK("unmapped read", 8'h00, rd_v)
    reg_wr(8'hcb);
    quiet(4);
    reg_rd(CAUSE_REG_ADDR, rd_v);
    `CHK("read-only bits", FLAGS_POR, rd_v)
    reg_wr(8'h12);
    cause(8'h10);
    cmp_out_i = 1'b0;
    quiet(6);
    cmp_out_i = 1'b1;
    reg_wr(8'h22);
    `CHK("cmp enable", 1'b1, cmp_reset_en_o)
    cmp_out_i = 1'b0;
    cause(8'h20);
    cmp_out_i = 1'b1;
    `CHK("cmp enable cleared", 1'b0, cmp_reset_en_o)
    pin_rst_n_i = 1'b0;
    step(HOLD * 3);
    `CHK("pin hold", 1'b1, sys_reset_o)
    pin_rst_n_i = 1'b1;
    cause(8'h01);
    reg_wr(8'h06);
    `CHK("mcd enable", 1'b1, mcd_en_o)
    reg_wr(8'h02);
    `CHK("mcd disable", 1'b0, mcd_en_o)
    clk_run = 1'b0;
    quiet(12);
    reg_wr(8'h06);
    cause(8'h04);
    clk_run = 1'b1;
    for (int i = 0; i < 7; i++) begin
      supply_monitor_level_i = !FL_LOW[i];
      flash_i = FL_CASE[i];
      step(1);
      flash_i = '0;
      if (FL_BAD[i]) cause(8'h40);
      else quiet(6);
    end
    supply_monitor_level_i = 1'b1;
    reg_wr(8'h00);
    `CHK("supply enable off", 1'b0, supply_reset_en_o)
    supply_trip_i = 1'b1;
    quiet(6);
    supply_trip_i = 1'b0;
    reg_wr(8'h02);
    supply_trip_i = 1'b1;
    step(1);
    supply_trip_i = 1'b0;
    cause(8'h02);
    repeat (4) begin
      quiet(WD_CYC / 2);
      wd_kick_i = 1'b1;
      step(1);
      wd_kick_i = 1'b0;
    end
    cause(8'h08);
    `CHK("watchdog rearmed", 1'b1, wd_enabled_o)
    wd_disable_i = 1'b1;
    step(1);
    wd_disable_i = 1'b0;
    quiet(WD_CYC + 50);
    `CHK("watchdog off", 1'b0, wd_enabled_o)
    reg_wr(8'h12);
    cause(8'h10);
    `CHK("watchdog back on", 1'b1, wd_enabled_o)
    test_done();
  end

  initial begin
    #(40000 * CLK_PERIOD_NS);
    n_mismatch++;
    test_done();
  end
endmodule // test_reset_source_logic
